// *** eec_enc_model.sv ***
`timescale 1ns/1ns
module eec_enc_model (
    // Clock
    input wire logic clk,
    // Tracks
    output logic a,
    output logic b,
    output logic r
);
    initial begin
        a = 1'b0;
        b = 1'b0;
        r = 1'b0;
    end
    // One signal period, A leading B when up; 4 cycles a phase
    // keeps edges well below the loss rate
    task automatic move(input logic up);
        logic [7:0] ph;
        ph = up ? 8'hB4 : 8'h78;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {a, b} <= ph[6 - 2 * i +: 2];
            repeat (3) @(posedge clk);
        end
        repeat (3) @(posedge clk);
    endtask : move
    task automatic mark();
        @(posedge clk);
        r <= 1'b1;
        repeat (3) @(posedge clk);
        r <= 1'b0;
        repeat (5) @(posedge clk);
    endtask : mark
endmodule : eec_enc_model

// *** eec_pkg.sv ***
package eec_pkg;

    // ------------------------------------------------------------
    // Register map, byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] EEC_OFF_CONFIG = 8'h00;
    localparam logic [7:0] EEC_OFF_PRESET = 8'h04;
    localparam logic [7:0] EEC_OFF_COMMAND = 8'h08;
    localparam logic [7:0] EEC_OFF_COUNT = 8'h0C;
    localparam logic [7:0] EEC_OFF_STATUS = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int EEC_CFG_EDGE_LSB = 0;
    localparam int EEC_CFG_STEP_LSB = 2;
    localparam int EEC_CFG_SENSE_BIT = 4;
    localparam int EEC_CFG_TALLY_BIT = 5;
    localparam int EEC_CFG_PERSIST_BIT = 6;
    localparam int EEC_CFG_EXPERT_BIT = 7;
    localparam int EEC_CFG_MEASURE_BIT = 8;
    localparam int EEC_CFG_SUBDIV_LSB = 16;
    localparam int EEC_CMD_LOAD_BIT = 0;
    localparam int EEC_STS_RUN_BIT = 0;
    localparam int EEC_STS_REF_BIT = 1;
    localparam int EEC_STS_SQUARE_BIT = 2;
    localparam int EEC_STS_INTERP_BIT = 3;
    localparam int EEC_STS_EDGE_LSB = 4;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [10:0] EEC_SUBDIV_MAX = 11'h400;
    localparam logic [10:0] EEC_SUBDIV_ONE = 11'h001;
    localparam logic [2:0] EEC_STEP_ONE_VAL = 3'h1;
    localparam logic [2:0] EEC_STEP_TWO_VAL = 3'h2;
    localparam logic [2:0] EEC_STEP_FIVE_VAL = 3'h5;
    localparam logic [31:0] EEC_COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] EEC_WORD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {EEC_EDGE_X1, EEC_EDGE_X2, EEC_EDGE_X4, EEC_EDGE_OFF} eec_edge_t;
    typedef enum logic [1:0] {EEC_STEP_1, EEC_STEP_2, EEC_STEP_5, EEC_STEP_RSVD} eec_step_t;
    typedef enum logic [0:0] {EEC_PH_RESTORE, EEC_PH_RUN} eec_phase_t;

    typedef struct packed {
        logic [10:0] subdivision_select;
        logic line_count_measure;
        logic expert;
        logic setup_persist_select;
        logic tally_start_select;
        logic count_sense_select;
        eec_step_t last_digit_step_select;
        eec_edge_t edge_multiplier_select;
    } eec_cfg_t;

    typedef struct packed {
        logic up;
        logic a_rise;
        logic a_edge;
        logic any_edge;
    } eec_qev_t;

    localparam eec_cfg_t EEC_CFG_RESET = '{
        subdivision_select: 11'h000,
        line_count_measure: 1'b0,
        expert: 1'b0,
        setup_persist_select: 1'b0,
        tally_start_select: 1'b0,
        count_sense_select: 1'b0,
        last_digit_step_select: EEC_STEP_1,
        edge_multiplier_select: EEC_EDGE_X1
    };

endpackage : eec_pkg

// *** eec_quad.sv ***
`timescale 1ns/1ns
module eec_quad (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Synchronised tracks
    input wire logic a,
    input wire logic b,
    // Events
    output eec_pkg::eec_qev_t qev
);

    typedef struct packed {
        logic primed;
        logic a_prev;
        logic b_prev;
    } eec_quad_state_t;

    eec_quad_state_t st;
    eec_quad_state_t next_st;
    logic a_chg;
    logic b_chg;

    // ------------------------------------------------------------
    // Phase decoding
    // ------------------------------------------------------------
    always_comb begin
        next_st.primed = 1'b1;
        next_st.a_prev = a;
        next_st.b_prev = b;
        // First sample after reset only primes the history
        a_chg = st.primed & (a ^ st.a_prev);
        b_chg = st.primed & (b ^ st.b_prev);
        // Both tracks moving at once carries no direction, so it is dropped
        qev.any_edge = a_chg ^ b_chg;
        qev.a_edge = a_chg & ~b_chg;
        qev.a_rise = qev.a_edge & a;
        // A leading B counts up
        qev.up = qev.a_edge ? (a != b) : (b == a);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    quad_dir_a: assert property (@(posedge clk) disable iff (rst)
        (st.primed && $rose(a) && !b && !$changed(b)) |-> qev.up && qev.a_rise)
        else $error("rising A with B low did not count up");

endmodule : eec_quad

// *** eec_sync.sv ***
`timescale 1ns/1ns
module eec_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } eec_sync_state_t;

    eec_sync_state_t st;
    eec_sync_state_t next_st;

    generate
        if (W < 1) begin : g_bad_width
            $error("eec_sync width must be positive");
        end
    endgenerate

    // ------------------------------------------------------------
    // Two stages; the first is read by the second only
    // ------------------------------------------------------------
    always_comb begin
        next_st.meta = din;
        next_st.stable = st.meta;
    end

    // No reset: the stages keep sampling, so levels are live at release
    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign dout = st.stable;

    sync_delay_a: assert property (@(posedge clk) disable iff (rst)
        (1'b1 ##2 1'b1) |-> dout == $past(din, 2))
        else $error("synchroniser delay is not two cycles");

endmodule : eec_sync

// *** eec_top.sv ***
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
module eec_top #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Wishbone slave
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_WE,
    input wire logic [7:0] WB_ADR,
    input wire logic [3:0] WB_SEL,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK,
    // Encoder signals
    input wire logic ENC_A,
    input wire logic ENC_B,
    input wire logic ENC_REF,
    input wire logic SQUARE_WAVE,
    // Settings store
    input wire logic NV_VALID,
    input wire logic [31:0] NV_DATA_IN,
    output logic NV_STORE,
    output logic [31:0] NV_DATA,
    // Position
    output logic [CNT_W-1:0] COUNT
);

    localparam int DELTA_W = 14;

    typedef struct packed {
        eec_pkg::eec_phase_t phase;
        eec_pkg::eec_cfg_t cfg;
        logic [CNT_W-1:0] preset;
        logic [CNT_W-1:0] count;
        logic running;
        logic ref_seen;
        logic ref_prev;
        logic ack;
        logic [31:0] dat_o;
        logic nv_store;
        logic [31:0] nv_data;
    } eec_top_state_t;

    eec_top_state_t st;
    eec_top_state_t next_st;
    logic [2:0] sync_lv;
    eec_pkg::eec_qev_t qev;
    eec_pkg::eec_edge_t eff_edge;
    logic ref_rise;
    logic interp_on;
    logic count_ev;
    logic load;
    logic req;
    logic acc;
    logic wr_cfg;
    logic [10:0] factor;
    logic [2:0] step_val;
    logic [DELTA_W-1:0] delta14;
    logic [CNT_W-1:0] delta;
    logic [31:0] rd_word;
    logic [31:0] status_word;
    logic [31:0] new_cfg_word;

    generate
        if (CNT_W < 16 || CNT_W > 32) begin : g_bad_cnt
            $error("eec_top CNT_W must lie in 16..32");
        end
    endgenerate

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
            input logic [31:0] new_w, input logic [3:0] sel);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_lanes

    function automatic logic [31:0] ext32(input logic [CNT_W-1:0] v);
        logic [31:0] r;
        r = eec_pkg::EEC_WORD_ZERO;
        r[CNT_W-1:0] = v;
        return r;
    endfunction : ext32

    function automatic logic [31:0] pack_cfg(input eec_pkg::eec_cfg_t c);
        logic [31:0] w;
        w = eec_pkg::EEC_WORD_ZERO;
        w[eec_pkg::EEC_CFG_EDGE_LSB +: 2] = c.edge_multiplier_select;
        w[eec_pkg::EEC_CFG_STEP_LSB +: 2] = c.last_digit_step_select;
        w[eec_pkg::EEC_CFG_SENSE_BIT] = c.count_sense_select;
        w[eec_pkg::EEC_CFG_TALLY_BIT] = c.tally_start_select;
        w[eec_pkg::EEC_CFG_PERSIST_BIT] = c.setup_persist_select;
        w[eec_pkg::EEC_CFG_EXPERT_BIT] = c.expert;
        w[eec_pkg::EEC_CFG_MEASURE_BIT] = c.line_count_measure;
        w[eec_pkg::EEC_CFG_SUBDIV_LSB +: 11] = c.subdivision_select;
        return w;
    endfunction : pack_cfg

    // Out-of-range fields are folded to legal settings on every load path
    function automatic eec_pkg::eec_cfg_t unpack_cfg(input logic [31:0] w);
        eec_pkg::eec_cfg_t c;
        c.edge_multiplier_select = eec_pkg::eec_edge_t'(w[eec_pkg::EEC_CFG_EDGE_LSB +: 2]);
        c.last_digit_step_select = eec_pkg::eec_step_t'(w[eec_pkg::EEC_CFG_STEP_LSB +: 2]);
        c.count_sense_select = w[eec_pkg::EEC_CFG_SENSE_BIT];
        c.tally_start_select = w[eec_pkg::EEC_CFG_TALLY_BIT];
        c.setup_persist_select = w[eec_pkg::EEC_CFG_PERSIST_BIT];
        c.expert = w[eec_pkg::EEC_CFG_EXPERT_BIT];
        c.line_count_measure = w[eec_pkg::EEC_CFG_MEASURE_BIT];
        c.subdivision_select = w[eec_pkg::EEC_CFG_SUBDIV_LSB +: 11];
        if (c.subdivision_select > eec_pkg::EEC_SUBDIV_MAX) begin
            c.subdivision_select = eec_pkg::EEC_SUBDIV_MAX;
        end
        if (c.last_digit_step_select == eec_pkg::EEC_STEP_RSVD) begin
            c.last_digit_step_select = eec_pkg::EEC_STEP_1;
        end
        if (c.subdivision_select != 11'h000) begin
            c.edge_multiplier_select = eec_pkg::EEC_EDGE_OFF;
        end else if (c.edge_multiplier_select == eec_pkg::EEC_EDGE_OFF) begin
            c.edge_multiplier_select = eec_pkg::EEC_EDGE_X1;
        end
        return c;
    endfunction : unpack_cfg

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    eec_sync #(
        .W(3)
    ) u_sync (
        .clk(MCLK),
        .rst(RST),
        .din({ENC_REF, ENC_B, ENC_A}),
        .dout(sync_lv)
    );

    eec_quad u_quad (
        .clk(MCLK),
        .rst(RST),
        .a(sync_lv[0]),
        .b(sync_lv[1]),
        .qev(qev)
    );

    // ------------------------------------------------------------
    // Count path
    // ------------------------------------------------------------
    always_comb begin
        ref_rise = sync_lv[2] & ~st.ref_prev;
        interp_on = ~SQUARE_WAVE & (st.cfg.subdivision_select != 11'h000);
        if (st.cfg.line_count_measure) begin
            eff_edge = eec_pkg::EEC_EDGE_X1;
        end else if (!SQUARE_WAVE || st.cfg.edge_multiplier_select == eec_pkg::EEC_EDGE_OFF) begin
            eff_edge = eec_pkg::EEC_EDGE_X1;
        end else begin
            eff_edge = st.cfg.edge_multiplier_select;
        end
        case (eff_edge)
            eec_pkg::EEC_EDGE_X4: count_ev = qev.any_edge;
            eec_pkg::EEC_EDGE_X2: count_ev = qev.a_edge;
            default: count_ev = qev.a_rise;
        endcase
        // Analog tracks are squared upstream; a period adds the whole factor
        factor = interp_on ? st.cfg.subdivision_select : eec_pkg::EEC_SUBDIV_ONE;
        step_val = eec_pkg::EEC_STEP_ONE_VAL;
        if (SQUARE_WAVE) begin
            case (st.cfg.last_digit_step_select)
                eec_pkg::EEC_STEP_2: step_val = eec_pkg::EEC_STEP_TWO_VAL;
                eec_pkg::EEC_STEP_5: step_val = eec_pkg::EEC_STEP_FIVE_VAL;
                default: step_val = eec_pkg::EEC_STEP_ONE_VAL;
            endcase
        end
        delta14 = {3'h0, factor} * {11'h000, step_val};
        delta = {{(CNT_W - DELTA_W){1'b0}}, delta14};
    end

    // ------------------------------------------------------------
    // Bus decode and next state
    // ------------------------------------------------------------
    always_comb begin
        req = WB_CYC & WB_STB;
        acc = req & st.ack;
        wr_cfg = acc & WB_WE & (WB_ADR == eec_pkg::EEC_OFF_CONFIG);
        load = acc & WB_WE & (WB_ADR == eec_pkg::EEC_OFF_COMMAND) & WB_SEL[0]
            & WB_DAT_I[eec_pkg::EEC_CMD_LOAD_BIT];
        new_cfg_word = merge_lanes(pack_cfg(st.cfg), WB_DAT_I, WB_SEL);
        status_word = eec_pkg::EEC_WORD_ZERO;
        status_word[eec_pkg::EEC_STS_RUN_BIT] = st.running;
        status_word[eec_pkg::EEC_STS_REF_BIT] = st.ref_seen;
        status_word[eec_pkg::EEC_STS_SQUARE_BIT] = SQUARE_WAVE;
        status_word[eec_pkg::EEC_STS_INTERP_BIT] = interp_on;
        status_word[eec_pkg::EEC_STS_EDGE_LSB +: 2] = eff_edge;
        if (WB_ADR == eec_pkg::EEC_OFF_CONFIG) begin
            rd_word = pack_cfg(st.cfg);
        end else if (WB_ADR == eec_pkg::EEC_OFF_PRESET) begin
            rd_word = ext32(st.preset);
        end else if (WB_ADR == eec_pkg::EEC_OFF_COUNT) begin
            rd_word = ext32(st.count);
        end else if (WB_ADR == eec_pkg::EEC_OFF_STATUS) begin
            rd_word = status_word;
        end else begin
            rd_word = eec_pkg::EEC_WORD_ZERO;
        end

        next_st = st;
        next_st.phase = eec_pkg::EEC_PH_RUN;
        next_st.ref_prev = sync_lv[2];
        next_st.ack = req & ~st.ack & (st.phase == eec_pkg::EEC_PH_RUN);
        next_st.nv_store = wr_cfg;
        if (req && !st.ack) begin
            next_st.dat_o = rd_word;
        end

        case (st.phase)
            eec_pkg::EEC_PH_RESTORE: begin
                if (NV_VALID) begin
                    next_st.cfg = unpack_cfg(NV_DATA_IN);
                    // Without persistence, advanced setup starts cleared
                    next_st.cfg.expert = NV_DATA_IN[eec_pkg::EEC_CFG_EXPERT_BIT]
                        & NV_DATA_IN[eec_pkg::EEC_CFG_PERSIST_BIT];
                end
            end
            default: begin
                if (wr_cfg) begin
                    next_st.cfg = unpack_cfg(new_cfg_word);
                    next_st.nv_data = pack_cfg(unpack_cfg(new_cfg_word));
                end
            end
        endcase

        if (acc && WB_WE && WB_ADR == eec_pkg::EEC_OFF_PRESET) begin
            next_st.preset = CNT_W'(merge_lanes(ext32(st.preset), WB_DAT_I, WB_SEL));
        end

        // Reference flag: a new pulse wins over a clear in the same cycle
        next_st.ref_seen = st.ref_seen;
        if (acc && WB_WE && WB_ADR == eec_pkg::EEC_OFF_STATUS && WB_SEL[0]
                && WB_DAT_I[eec_pkg::EEC_STS_REF_BIT]) begin
            next_st.ref_seen = 1'b0;
        end
        if (ref_rise) begin
            next_st.ref_seen = 1'b1;
        end

        if (load) begin
            next_st.count = st.preset;
            next_st.running = ~st.cfg.tally_start_select;
        end else begin
            if (st.running && count_ev) begin
                if (qev.up ^ st.cfg.count_sense_select) begin
                    next_st.count = st.count + delta;
                end else begin
                    next_st.count = st.count - delta;
                end
            end
            if (!st.running && (ref_rise || !st.cfg.tally_start_select)) begin
                next_st.running = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            st.phase <= eec_pkg::EEC_PH_RESTORE;
            st.cfg <= eec_pkg::EEC_CFG_RESET;
            st.preset <= eec_pkg::EEC_COUNT_RESET[CNT_W-1:0];
            st.count <= eec_pkg::EEC_COUNT_RESET[CNT_W-1:0];
            st.running <= 1'b1;
            st.ref_seen <= 1'b0;
            st.ref_prev <= sync_lv[2];
            st.ack <= 1'b0;
            st.dat_o <= eec_pkg::EEC_WORD_ZERO;
            st.nv_store <= 1'b0;
            st.nv_data <= eec_pkg::EEC_WORD_ZERO;
        end else begin
            st <= next_st;
        end
    end

    assign WB_ACK = st.ack;
    assign WB_DAT_O = st.dat_o;
    assign NV_STORE = st.nv_store;
    assign NV_DATA = st.nv_data;
    assign COUNT = st.count;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    edge_count_a: assert property (
        (!load && st.running && eff_edge == eec_pkg::EEC_EDGE_X4 && qev.any_edge)
        |=> st.count != $past(st.count))
        else $error("four-fold edge did not move the count");
    square_mult_a: assert property (
        !SQUARE_WAVE |-> eff_edge == eec_pkg::EEC_EDGE_X1)
        else $error("edge multiplication active on analog input");
    measure_single_a: assert property (
        (st.cfg.line_count_measure && qev.any_edge && !qev.a_rise && !load)
        |=> $stable(st.count))
        else $error("line count measurement counted a non-rising edge");
    interp_off_a: assert property (
        (wr_cfg && WB_SEL == 4'hF && WB_DAT_I[eec_pkg::EEC_CFG_SUBDIV_LSB +: 11] != 11'h000)
        |=> st.cfg.edge_multiplier_select == eec_pkg::EEC_EDGE_OFF)
        else $error("edge setting not forced inactive by subdivision");
    subdiv_max_a: assert property (
        st.cfg.subdivision_select <= eec_pkg::EEC_SUBDIV_MAX)
        else $error("subdivision factor above maximum");
    interp_analog_a: assert property (
        SQUARE_WAVE |-> factor == eec_pkg::EEC_SUBDIV_ONE)
        else $error("subdivision applied to square-wave input");
    step_five_a: assert property (
        (SQUARE_WAVE && st.cfg.last_digit_step_select == eec_pkg::EEC_STEP_5)
        |-> delta14 == 14'h0005)
        else $error("step of five not applied");
    step_square_a: assert property (
        !SQUARE_WAVE |-> step_val == eec_pkg::EEC_STEP_ONE_VAL)
        else $error("last digit step applied to analog input");
    sense_dir_a: assert property (
        (!load && st.running && count_ev && (qev.up ^ st.cfg.count_sense_select))
        |=> st.count == $past(st.count) + $past(delta))
        else $error("forward count did not add the step");
    persist_clear_a: assert property (
        (st.phase == eec_pkg::EEC_PH_RESTORE && NV_VALID
            && !NV_DATA_IN[eec_pkg::EEC_CFG_PERSIST_BIT]) |=> !st.cfg.expert)
        else $error("advanced setup kept without persistence");
    ref_hold_a: assert property (
        (!st.running && !load) |=> $stable(st.count))
        else $error("count moved while waiting for reference");
    preset_load_a: assert property (
        load |=> st.count == $past(st.preset)
            && st.running == !$past(st.cfg.tally_start_select))
        else $error("preset not loaded as start value");
    nv_store_a: assert property (
        wr_cfg |=> NV_STORE && NV_DATA == pack_cfg(st.cfg))
        else $error("changed setting not sent to store");
    ack_pulse_a: assert property (
        WB_ACK |=> !WB_ACK)
        else $error("bus acknowledge longer than one cycle");

    x4_count_c: cover property (count_ev && eff_edge == eec_pkg::EEC_EDGE_X4 && st.running);
    ref_start_c: cover property (!st.running && ref_rise && st.cfg.tally_start_select);
    preset_c: cover property (load ##1 st.count != eec_pkg::EEC_COUNT_RESET[CNT_W-1:0]);
    restore_c: cover property (st.phase == eec_pkg::EEC_PH_RESTORE && NV_VALID);

endmodule : eec_top

// *** tb_encoder_edge_counter.sv ***
`timescale 1ns/1ns
module tb_encoder_edge_counter;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic sq = 1'b1;
    logic [31:0] rdat;
    logic ack;
    logic [3:0] sel = 4'hF;
    logic [3:0] bsel = 4'hF;
    logic nv_valid = 1'b0;
    logic [31:0] nv_din = 32'h0000_0000;
    logic nv_store;
    logic a;
    logic b;
    logic r;
    logic [31:0] nv_data;
    logic [31:0] count;
    logic [31:0] v;
    logic [31:0] exp_cnt;
    int error_cnt = 0;
    int compares = 0;
    always #50 clk = ~clk;
    eec_top u_dut (.MCLK(clk), .RST(rst), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
        .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK(ack),
        .ENC_A(a), .ENC_B(b), .ENC_REF(r), .SQUARE_WAVE(sq), .NV_VALID(nv_valid),
        .NV_DATA_IN(nv_din), .NV_STORE(nv_store), .NV_DATA(nv_data), .COUNT(count));
    eec_enc_model u_enc (.clk(clk), .a(a), .b(b), .r(r));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        sel <= bsel;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        v = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic reboot(input logic [31:0] w);
        @(posedge clk);
        rst <= 1'b1;
        nv_valid <= 1'b1;
        nv_din <= w;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        nv_valid <= 1'b0;
    endtask : reboot
    task automatic wrap_up();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #2000000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        exp_cnt = 32'h0000_0000;
        wb(1'b0, eec_pkg::EEC_OFF_CONFIG, 32'h0000_0000);
        chk(v, 32'h0000_0000);
        // Edge modes X1, X2 and X4 paired with steps 1, 2 and 5 in turn
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, eec_pkg::EEC_OFF_CONFIG, i | (i << 2));
            @(negedge clk);
            chk(nv_data, i | (i << 2));
            chk({31'h0000_0000, nv_store}, 32'h0000_0001);
            u_enc.move(1'b1);
            exp_cnt += (1 << i) * ((i == 2) ? 5 : i + 1);
            chk(count, exp_cnt);
        end
        wb(1'b1, eec_pkg::EEC_OFF_CONFIG, 32'h0000_0016);
        u_enc.move(1'b1);
        exp_cnt -= 8;
        chk(count, exp_cnt);
        u_enc.move(1'b0);
        exp_cnt += 8;
        chk(count, exp_cnt);
        wb(1'b1, eec_pkg::EEC_OFF_CONFIG, 32'h0000_0102);
        u_enc.move(1'b1);
        exp_cnt += 1;
        chk(count, exp_cnt);
        $display("test square done");
        sq <= 1'b0;
        wb(1'b1, eec_pkg::EEC_OFF_CONFIG, 32'h0000_000A);
        u_enc.move(1'b1);
        exp_cnt += 1;
        chk(count, exp_cnt);
        wb(1'b1, eec_pkg::EEC_OFF_CONFIG, 32'h0005_000A);
        wb(1'b0, eec_pkg::EEC_OFF_CONFIG, 32'h0000_0000);
        chk(v, 32'h0005_000B);
        u_enc.move(1'b1);
        exp_cnt += 5;
        chk(count, exp_cnt);
        wb(1'b1, eec_pkg::EEC_OFF_CONFIG, 32'h07FF_0000);
        wb(1'b0, eec_pkg::EEC_OFF_CONFIG, 32'h0000_0000);
        chk(v, 32'h0400_0003);
        $display("test analog done");
        sq <= 1'b1;
        wb(1'b1, eec_pkg::EEC_OFF_PRESET, 32'h0000_1234);
        wb(1'b1, eec_pkg::EEC_OFF_CONFIG, 32'h0000_0020);
        wb(1'b1, eec_pkg::EEC_OFF_COMMAND, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(count, 32'h0000_1234);
        u_enc.move(1'b1);
        chk(count, 32'h0000_1234);
        u_enc.mark();
        u_enc.move(1'b1);
        chk(count, 32'h0000_1235);
        wb(1'b0, eec_pkg::EEC_OFF_STATUS, 32'h0000_0000);
        chk(v, 32'h0000_0007);
        wb(1'b1, eec_pkg::EEC_OFF_STATUS, 32'h0000_0002);
        wb(1'b0, eec_pkg::EEC_OFF_STATUS, 32'h0000_0000);
        chk(v, 32'h0000_0005);
        bsel = 4'h1;
        wb(1'b1, eec_pkg::EEC_OFF_PRESET, 32'hFFFF_FF56);
        bsel = 4'hE;
        wb(1'b1, eec_pkg::EEC_OFF_COMMAND, 32'h0000_0001);
        bsel = 4'hF;
        wb(1'b0, eec_pkg::EEC_OFF_COUNT, 32'h0000_0000);
        chk(v, 32'h0000_1235);
        wb(1'b0, eec_pkg::EEC_OFF_PRESET, 32'h0000_0000);
        chk(v, 32'h0000_1256);
        wb(1'b0, 8'h20, 32'h0000_0000);
        chk(v, 32'h0000_0000);
        $display("test preset done");
        reboot(32'h0000_0094);
        wb(1'b0, eec_pkg::EEC_OFF_CONFIG, 32'h0000_0000);
        chk(v, 32'h0000_0014);
        chk(count, 32'h0000_0000);
        reboot(32'h0000_00C0);
        wb(1'b0, eec_pkg::EEC_OFF_CONFIG, 32'h0000_0000);
        chk(v, 32'h0000_00C0);
        $display("test restore done");
        wrap_up();
    end
endmodule : tb_encoder_edge_counter
